// *** src/uhs_pkg.sv ***
package uhs_pkg;
  localparam int          UHS_CLK_HZ        = 250_000_000;
  localparam int          UHS_MIN_BPS       = 1500;
  localparam int          UHS_MAX_BPS       = 12_000_000;
  localparam int          UHS_DEF_BPS       = 1_000_000;
  // Half-bit divider counts, in clock cycles
  localparam int          UHS_HALF_MIN_CYC  = UHS_CLK_HZ / (2 * UHS_MAX_BPS);
  localparam int          UHS_HALF_MAX_CYC  = UHS_CLK_HZ / (2 * UHS_MIN_BPS);
  localparam logic [16:0] UHS_DEF_HALF      = 17'(UHS_CLK_HZ / (2 * UHS_DEF_BPS));
  localparam logic [15:0] UHS_DEF_LEN       = 16'h0004;
  localparam logic [8:0]  UHS_DEF_CS_SEL    = 9'h002;
  localparam logic [8:0]  UHS_DEF_CS_IDLE   = 9'h1FF;
  localparam logic [8:0]  UHS_DEF_CS_ACT    = 9'h000;
  localparam logic [1:0]  UHS_DEF_MODE      = 2'h0;
  localparam logic [15:0] UHS_DEF_DELAY     = 16'h0000;
  localparam int          UHS_BUF_BYTES     = 64;
  localparam int          UHS_PIN_SUSPEND   = 2;
  localparam int          UHS_PIN_TRAFFIC   = 3;
  localparam int          UHS_PIN_LOW_POWER_INDICATOR    = 4;
  localparam int          UHS_PIN_CFG       = 5;
  localparam int          UHS_PIN_ACK       = 7;
  localparam int          UHS_PIN_REQ       = 8;
  // Pin function codes
  localparam logic [1:0]  UHS_FN_GPIO       = 2'h0;
  localparam logic [1:0]  UHS_FN_CS         = 2'h1;
  localparam logic [1:0]  UHS_FN_DED        = 2'h2;
  typedef enum logic [2:0] {UHS_IDLE, UHS_PRE, UHS_BIT, UHS_GAP, UHS_POST, UHS_REL} uhs_st_e;
endpackage

// *** src/uhs_spi_bridge.sv ***
// Behaviour
// - Four SPI modes selectable per transfer
// - Bit rate programmable 1500 bps to 12 Mbps
// - Pre, inter-byte and post delays programmable
// - Up to 65535 bytes, chip selects held
// - Nine chip selects, line n on pin n
// - Drive pin as select only if configured
// - Reset defaults: 1 Mbit, 4 bytes, pin 1
// - Only host commands control; SPI never commands
// - Enumerates solely as HID function
// - 64-byte transmit and receive buffering
// - Suspend shown on pin 2 when dedicated
// - Resume on resume, bus reset, device reset
// - Six pins have dedicated alternate functions
// - Descriptors and settings rewritable, held on chip
// - Power source selectable, bus-powered default
// - Suspend indicator low suspended, high resumed
// - Configured indicator high reset, low configured and not suspended
// - Traffic indicator low during transfer
// - Release bus only after transfer ends/cancels
module uhs_spi_bridge
  import uhs_pkg::*;
#(
  parameter int BUF_DEPTH = UHS_BUF_BYTES
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  // Host command side (USB protocol engine)
  input  wire logic        cfg_we,
  input  wire logic [1:0]  cfg_mode,
  input  wire logic [16:0] cfg_half_cyc,
  input  wire logic [15:0] cfg_len,
  input  wire logic [15:0] cfg_pre_dly,
  input  wire logic [15:0] cfg_gap_dly,
  input  wire logic [15:0] cfg_post_dly,
  input  wire logic [8:0]  cfg_cs_sel,
  input  wire logic [8:0]  cfg_cs_idle,
  input  wire logic [8:0]  cfg_cs_act,
  input  wire logic [17:0] pin_func,
  input  wire logic        self_powered_we,
  input  wire logic        self_powered_in,
  output logic             self_powered,
  input  wire logic        xfer_start,
  input  wire logic        xfer_cancel,
  output logic             xfer_busy,
  output logic             xfer_done,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  output logic             rx_valid,
  output logic [7:0]       rx_data,
  input  wire logic        rx_ready,
  // USB state events
  input  wire logic        usb_suspend_det,
  input  wire logic        usb_resume_det,
  input  wire logic        usb_bus_reset,
  input  wire logic        usb_configured_ev,
  output logic             hid_only,
  output logic             usb_suspended,
  // SPI pins
  output logic             sck,
  output logic             mosi,
  input  wire logic        miso,
  // General pins 0..8
  input  wire logic [8:0]  gen_pin_in,
  output logic [8:0]       gen_pin_out,
  output logic [8:0]       gen_pin_oe,
  output logic [8:0]       gen_pin_gpio_in
);
  initial begin
    if (BUF_DEPTH < 2 || BUF_DEPTH > 256) $error("BUF_DEPTH out of range");
  end
  localparam int AW = $clog2(BUF_DEPTH);

  assign hid_only = 1'b1;

  // Input synchronisers
  logic [8:0] pin_s1, pin_s2;
  logic       miso_s1, miso_s2;
  always_ff @(posedge clock) begin
    pin_s1  <= gen_pin_in;
    pin_s2  <= pin_s1;
    miso_s1 <= miso;
    miso_s2 <= miso_s1;
  end
  assign gen_pin_gpio_in = pin_s2;

  // Transfer settings held on chip
  logic [1:0]  mode;
  logic [16:0] half_cyc;
  logic [15:0] len, pre_dly, gap_dly, post_dly;
  logic [8:0]  cs_sel, cs_idle, cs_act;
  logic        usb_cfg, susp, pwr;
  logic [1:0]  next_mode;
  logic [16:0] next_half_cyc;
  logic [15:0] next_len, next_pre_dly, next_gap_dly, next_post_dly;
  logic [8:0]  next_cs_sel, next_cs_idle, next_cs_act;
  logic        next_usb_cfg, next_susp, next_pwr;

  always_comb begin
    next_mode     = mode;
    next_half_cyc = half_cyc;
    next_len      = len;
    next_pre_dly  = pre_dly;
    next_gap_dly  = gap_dly;
    next_post_dly = post_dly;
    next_cs_sel   = cs_sel;
    next_cs_idle  = cs_idle;
    next_cs_act   = cs_act;
    next_pwr      = pwr;
    if (cfg_we && !xfer_busy) begin
      next_mode     = cfg_mode;
      next_half_cyc = cfg_half_cyc < 17'(UHS_HALF_MIN_CYC) ? 17'(UHS_HALF_MIN_CYC) :
                      cfg_half_cyc > 17'(UHS_HALF_MAX_CYC) ? 17'(UHS_HALF_MAX_CYC) :
                      cfg_half_cyc;
      next_len      = cfg_len;
      next_pre_dly  = cfg_pre_dly;
      next_gap_dly  = cfg_gap_dly;
      next_post_dly = cfg_post_dly;
      next_cs_sel   = cfg_cs_sel;
      next_cs_idle  = cfg_cs_idle;
      next_cs_act   = cfg_cs_act;
    end
    if (self_powered_we) begin
      next_pwr = self_powered_in;
    end
    // Resume wins over suspend; bus reset drops configuration
    next_susp = susp;
    next_usb_cfg = usb_cfg;
    if (usb_suspend_det) begin
      next_susp = 1'b1;
    end
    if (usb_resume_det || usb_bus_reset) begin
      next_susp = 1'b0;
    end
    if (usb_configured_ev) begin
      next_usb_cfg = 1'b1;
    end
    if (usb_bus_reset) begin
      next_usb_cfg = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mode     <= UHS_DEF_MODE;
      half_cyc <= UHS_DEF_HALF;
      len      <= UHS_DEF_LEN;
      pre_dly  <= UHS_DEF_DELAY;
      gap_dly  <= UHS_DEF_DELAY;
      post_dly <= UHS_DEF_DELAY;
      cs_sel   <= UHS_DEF_CS_SEL;
      cs_idle  <= UHS_DEF_CS_IDLE;
      cs_act   <= UHS_DEF_CS_ACT;
      pwr      <= 1'b0;
      susp     <= 1'b0;
      usb_cfg  <= 1'b0;
    end else begin
      mode     <= next_mode;
      half_cyc <= next_half_cyc;
      len      <= next_len;
      pre_dly  <= next_pre_dly;
      gap_dly  <= next_gap_dly;
      post_dly <= next_post_dly;
      cs_sel   <= next_cs_sel;
      cs_idle  <= next_cs_idle;
      cs_act   <= next_cs_act;
      pwr      <= next_pwr;
      susp     <= next_susp;
      usb_cfg  <= next_usb_cfg;
    end
  end
  assign self_powered  = pwr;
  assign usb_suspended = susp;

  // Transmit buffer
  logic [7:0]  tx_mem [BUF_DEPTH];
  logic [AW:0] tx_wp, tx_rp, next_tx_wp, next_tx_rp;
  logic        tx_pop;
  assign tx_ready = (tx_wp - tx_rp) != (AW+1)'(BUF_DEPTH);
  always_comb begin
    next_tx_wp = tx_wp;
    next_tx_rp = tx_rp;
    if (tx_valid && tx_ready) begin
      next_tx_wp = tx_wp + 1'b1;
    end
    if (tx_pop) begin
      next_tx_rp = tx_rp + 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_wp <= '0;
      tx_rp <= '0;
    end else begin
      tx_wp <= next_tx_wp;
      tx_rp <= next_tx_rp;
    end
    if (tx_valid && tx_ready) begin
      tx_mem[tx_wp[AW-1:0]] <= tx_data;
    end
  end
  logic tx_have;
  assign tx_have = tx_wp != tx_rp;

  // Receive buffer
  logic [7:0]  rx_mem [BUF_DEPTH];
  logic [AW:0] rx_wp, rx_rp, next_rx_wp, next_rx_rp;
  logic        rx_push, rx_room;
  logic [7:0]  rx_byte;
  assign rx_room  = (rx_wp - rx_rp) != (AW+1)'(BUF_DEPTH);
  assign rx_valid = rx_wp != rx_rp;
  assign rx_data  = rx_mem[rx_rp[AW-1:0]];
  always_comb begin
    next_rx_wp = rx_wp;
    next_rx_rp = rx_rp;
    if (rx_push) begin
      next_rx_wp = rx_wp + 1'b1;
    end
    if (rx_valid && rx_ready) begin
      next_rx_rp = rx_rp + 1'b1;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_wp <= '0;
      rx_rp <= '0;
    end else begin
      rx_wp <= next_rx_wp;
      rx_rp <= next_rx_rp;
    end
    if (rx_push) begin
      rx_mem[rx_wp[AW-1:0]] <= rx_byte;
    end
  end

  // SPI engine
  uhs_st_e     st, next_st;
  logic [16:0] cnt, next_cnt;
  logic [15:0] left, next_left;
  logic [3:0]  edg, next_edg;
  logic [7:0]  sh, next_sh;
  logic        sck_r, next_sck_r, done_r, next_done_r;
  logic        mosi_r, next_mosi_r;
  logic        cpol, cpha, lead;
  assign cpol = mode[1];
  assign cpha = mode[0];
  assign lead = edg[0] == 1'b0; // even edges are the first of each bit

  always_comb begin
    next_st     = st;
    next_cnt    = cnt;
    next_left   = left;
    next_edg    = edg;
    next_sh     = sh;
    next_sck_r  = sck_r;
    next_done_r = 1'b0;
    next_mosi_r = mosi_r;
    tx_pop      = 1'b0;
    rx_push     = 1'b0;
    rx_byte     = {sh[6:0], miso_s2};
    unique case (st)
      UHS_IDLE: begin
        next_sck_r = cpol;
        if (xfer_start && len != 16'h0000) begin
          next_st   = UHS_PRE;
          next_cnt  = {1'b0, pre_dly};
          next_left = len;
        end
      end
      UHS_PRE, UHS_GAP: begin
        if (xfer_cancel) begin
          next_st = UHS_POST;
          next_cnt = {1'b0, post_dly};
        end else if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (tx_have && rx_room) begin
          next_sh  = tx_mem[tx_rp[AW-1:0]];
          tx_pop   = 1'b1;
          next_mosi_r = tx_mem[tx_rp[AW-1:0]][7];
          next_edg = '0;
          next_cnt = half_cyc;
          next_st  = UHS_BIT;
        end
      end
      UHS_BIT: begin
        if (xfer_cancel) begin
          next_st = UHS_POST;
          next_cnt = {1'b0, post_dly};
          next_sck_r = cpol;
        end else if (cnt > 17'h0_0001) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_cnt   = half_cyc;
          next_sck_r = ~sck_r;
          next_edg   = edg + 1'b1;
          // Data line moves only on the edge the slave does not sample
          if (lead == cpha) begin
            next_mosi_r = sh[7];
          end
          // Sample on leading edge when phase is 0, trailing when 1
          if (lead != cpha) begin
            next_sh = {sh[6:0], miso_s2};
          end else if (edg != 4'h0 || cpha) begin
            next_sh = sh; // shift happens on the next sample edge
          end
          if (edg == 4'hF) begin
            rx_push   = 1'b1;
            next_left = left - 1'b1;
            rx_byte   = cpha ? {sh[6:0], miso_s2} : sh;
            next_sh   = sh;
            if (left == 16'h0001) begin
              next_st  = UHS_POST;
              next_cnt = {1'b0, post_dly};
            end else begin
              next_st  = UHS_GAP;
              next_cnt = {1'b0, gap_dly};
            end
          end
        end
      end
      UHS_POST: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else begin
          next_st     = UHS_REL;
          next_done_r = 1'b1;
        end
      end
      UHS_REL: begin
        next_st = UHS_IDLE;
      end
      default: begin
        next_st = UHS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st     <= UHS_IDLE;
      cnt    <= '0;
      left   <= '0;
      edg    <= '0;
      sh     <= '0;
      sck_r  <= 1'b0;
      done_r <= 1'b0;
      mosi_r <= 1'b0;
    end else begin
      st     <= next_st;
      cnt    <= next_cnt;
      left   <= next_left;
      edg    <= next_edg;
      sh     <= next_sh;
      sck_r  <= next_sck_r;
      done_r <= next_done_r;
      mosi_r <= next_mosi_r;
    end
  end

  assign xfer_busy = st != UHS_IDLE && st != UHS_REL;
  assign xfer_done = done_r;
  assign sck  = sck_r;
  assign mosi = mosi_r;

  // Bus release: acknowledge only while no transfer runs
  logic rel_ack;
  assign rel_ack = pin_func[2*UHS_PIN_REQ +: 2] == UHS_FN_DED && !pin_s2[UHS_PIN_REQ]
                   && !xfer_busy;

  // Pin function mux
  logic [8:0] ded_val;
  always_comb begin
    ded_val = 9'h1FF;
    ded_val[UHS_PIN_SUSPEND] = !susp;
    ded_val[UHS_PIN_TRAFFIC] = !xfer_busy;
    ded_val[UHS_PIN_LOW_POWER_INDICATOR]  = usb_cfg && !susp;
    ded_val[UHS_PIN_CFG]     = !(usb_cfg && !susp);
    ded_val[UHS_PIN_ACK]     = !rel_ack;
  end
  genvar gi;
  for (gi = 0; gi < 9; gi++) begin : g_pin
    logic [1:0] fn;
    logic       is_out;
    assign fn = pin_func[2*gi +: 2];
    assign is_out = gi != 6 && gi != UHS_PIN_REQ;
    always_comb begin
      gen_pin_out[gi] = 1'b0;
      gen_pin_oe[gi]  = 1'b0;
      if (fn == UHS_FN_CS) begin
        gen_pin_oe[gi]  = 1'b1;
        gen_pin_out[gi] = (xfer_busy && cs_sel[gi]) ? cs_act[gi] : cs_idle[gi];
      end else if (fn == UHS_FN_DED && is_out) begin
        gen_pin_oe[gi]  = 1'b1;
        gen_pin_out[gi] = ded_val[gi];
      end
    end
  end
endmodule

// *** verification/uhs_spi_bridge_checker.sv ***
module uhs_checker
  import uhs_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        cfg_we,
  input wire logic [1:0]  cfg_mode,
  input wire logic [8:0]  cfg_cs_sel,
  input wire logic [8:0]  cfg_cs_idle,
  input wire logic [8:0]  cfg_cs_act,
  input wire logic [17:0] pin_func,
  input wire logic        self_powered_we,
  input wire logic        self_powered_in,
  input wire logic        self_powered,
  input wire logic        xfer_start,
  input wire logic        xfer_busy,
  input wire logic        xfer_done,
  input wire logic        usb_suspend_det,
  input wire logic        usb_resume_det,
  input wire logic        usb_bus_reset,
  input wire logic        hid_only,
  input wire logic        usb_suspended,
  input wire logic        sck,
  input wire logic [8:0]  gen_pin_out,
  input wire logic [8:0]  gen_pin_oe
);
  logic [28:0] cfg;
  logic [28:0] next_cfg;
  logic [8:0]  cs_m;
  logic [8:0]  gp_m;
  logic [8:0]  exp_cs;
  // Shadow of the settings the engine should hold
  always_comb begin
    next_cfg = cfg;
    if (cfg_we && !xfer_busy) begin
      next_cfg = {cfg_mode, cfg_cs_sel, cfg_cs_idle, cfg_cs_act};
    end
    if (!rst_b) begin
      next_cfg = {UHS_DEF_MODE, UHS_DEF_CS_SEL, UHS_DEF_CS_IDLE, UHS_DEF_CS_ACT};
    end
    for (int i = 0; i < 9; i++) begin
      cs_m[i] = pin_func[2*i+:2] == UHS_FN_CS;
      gp_m[i] = pin_func[2*i+:2] == UHS_FN_GPIO;
    end
    exp_cs = xfer_busy ? (cfg[26:18] & cfg[8:0] | ~cfg[26:18] & cfg[17:9]) : cfg[17:9];
  end
  always_ff @(posedge clock) begin
    cfg <= next_cfg;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_start_busy: assert property (xfer_start && !xfer_busy && !xfer_done
    |=> xfer_busy) else $error("start not taken");
  a_done_ends: assert property (xfer_done |-> !xfer_busy && $past(xfer_busy))
    else $error("done not right after busy");
  a_pin_owner: assert property ((gen_pin_oe & (gp_m | cs_m)) == cs_m)
    else $error("pin drive wrong");
  a_cs_level: assert property (xfer_busy == $past(xfer_busy) && !$past(cfg_we)
    |-> ((gen_pin_out ^ exp_cs) & cs_m) == 9'h000) else $error("select level wrong");
  a_traffic_pin: assert property (pin_func[7:6] == UHS_FN_DED
    && xfer_busy == $past(xfer_busy) |-> gen_pin_out[3] == !xfer_busy) else $error("traffic pin");
  a_sck_hold: assert property ($changed(sck) && sck != cfg[28] |=> $stable(sck)[*8])
    else $error("clock half too short");
  a_sck_rest: assert property (xfer_done |-> sck == cfg[28])
    else $error("clock not at rest");
  a_hid_only: assert property (hid_only)
    else $error("not hid only");
  a_suspend_on: assert property (usb_suspend_det && !usb_resume_det && !usb_bus_reset
    |=> usb_suspended) else $error("suspend missed");
  a_resume_off: assert property (usb_resume_det || usb_bus_reset |=> !usb_suspended)
    else $error("resume missed");
  a_suspend_pin: assert property (pin_func[5:4] == UHS_FN_DED && $stable(usb_suspended)
    |-> gen_pin_out[2] == !usb_suspended) else $error("suspend pin");
  a_power_sel: assert property (self_powered_we
    |=> self_powered == $past(self_powered_in)) else $error("power source");
  c_done: cover property (xfer_done);
  c_resume: cover property ($fell(usb_suspended));
  c_power: cover property (self_powered_we);
endmodule

bind uhs_spi_bridge uhs_checker i_uhs_checker (.*);

// *** verification/uhs_slave.sv ***
module uhs_slave (
  input  wire logic       sck,
  input  wire logic       cs_b,
  input  wire logic       mosi,
  input  wire logic [1:0] mode,
  output logic            miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [0:63];
  logic [7:0] sh;
  int         n;
  function automatic logic tx_bit(int i);
    logic [7:0] b;
    b = 8'ha5 ^ 8'(i / 8);
    return b[7 - i % 8];
  endfunction
  // Released line shows the inverse of its last bit
  always @(cs_b) begin
    n = 0;
    miso = cs_b ? ~miso : tx_bit(0);
  end
  always @(sck) begin
    if (!cs_b && sck == ~(mode[1] ^ mode[0])) begin
      sh = {sh[6:0], mosi};
      if (n % 8 == 7) got[n / 8 % 64] = sh;
      n++;
    end else if (!cs_b) begin
      miso = tx_bit(n);
    end
  end
endmodule

// *** verification/test_usb_hid_spi_master_bridge.sv ***
module test_usb_hid_spi_master_bridge
  import uhs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] md;
    logic [8:0] sel;
    logic [7:0] pre;
    logic [7:0] gap;
    logic [7:0] post;
  } uhs_row_s;
  logic        clock, rst_b, cfg_we, self_powered_we, self_powered_in, xfer_start;
  logic        xfer_cancel, tx_valid, rx_ready, usb_suspend_det, usb_resume_det;
  logic        usb_bus_reset, usb_configured_ev, self_powered, xfer_busy, xfer_done;
  logic        tx_ready, rx_valid, hid_only, usb_suspended, sck, mosi, miso, cs_b, sck_q;
  logic [1:0]  cfg_mode;
  logic [7:0]  tx_data, rx_data;
  logic [8:0]  cfg_cs_sel, cfg_cs_idle, cfg_cs_act, gen_pin_out, gen_pin_oe;
  logic [8:0]  gen_pin_in, gen_pin_gpio_in;
  logic [15:0] cfg_len, cfg_pre_dly, cfg_gap_dly, cfg_post_dly;
  logic [16:0] cfg_half_cyc;
  logic [17:0] pin_func;
  int          errors, checks_done, span, run_c, cyc, base;
  uhs_row_s    rows [0:3] = '{'{2'h0, 9'h002, 8'h00, 8'h00, 8'h00},
    '{2'h1, 9'h001, 8'h05, 8'h00, 8'h00}, '{2'h2, 9'h003, 8'h00, 8'h07, 8'h00},
    '{2'h3, 9'h002, 8'h00, 8'h00, 8'h09}};
  uhs_spi_bridge i_uhs_spi_bridge (.*);
  uhs_slave i_uhs_slave (.sck(sck), .cs_b(cs_b), .mosi(mosi), .mode(cfg_mode), .miso(miso));
  assign cs_b = &(gen_pin_out[1:0] | ~gen_pin_oe[1:0]);
  initial begin
    clock = 0;
    forever #2 clock = ~clock;
  end
  // Cycles between the last two clock-line edges
  always @(negedge clock) begin
    run_c <= (sck != sck_q) ? 1 : run_c + 1;
    if (sck != sck_q) span <= run_c;
    sck_q <= sck;
  end
  task automatic chk(string nm, int exp, logic [31:0] got);
    checks_done++;
    if (got !== 32'(exp)) begin
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      errors++;
    end
  endtask
  task automatic close_out();
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    @(negedge clock);
    s = 0;
    repeat (3) @(negedge clock);
  endtask
  task automatic setup(uhs_row_s r, logic [15:0] len);
    {cfg_mode, cfg_cs_sel, cfg_len} = {r.md, r.sel, len};
    {cfg_pre_dly, cfg_gap_dly, cfg_post_dly} = {8'h00, r.pre, 8'h00, r.gap, 8'h00, r.post};
    pulse(cfg_we);
  endtask
  task automatic push(logic [7:0] d);
    tx_valid = 1;
    tx_data = d;
    @(negedge clock);
    tx_valid = 0;
  endtask
  task automatic pull(int k, logic [7:0] d);
    for (int i = 0; i < 50 && rx_valid !== 1'b1; i++) @(negedge clock);
    if (rx_valid !== 1'b1) chk("rx wait", 1, 0);
    chk("rx byte", 8'ha5 ^ k, rx_data);
    chk("mosi byte", d, i_uhs_slave.got[k]);
    rx_ready = 1;
    @(negedge clock);
    rx_ready = 0;
  endtask
  task automatic run(logic poke, logic stop);
    xfer_start = 1;
    @(negedge clock);
    {xfer_start, cfg_we, xfer_cancel} = {1'b0, poke, stop};
    @(negedge clock);
    {cfg_we, xfer_cancel} = 0;
    for (cyc = 0; xfer_busy !== 1'b0; cyc++) begin
      @(negedge clock);
      if (cyc > 30000) begin
        chk("busy timeout", 0, 1);
        close_out();
      end
    end
  endtask
  initial begin
    {rst_b, cfg_we, self_powered_we, self_powered_in, xfer_start, xfer_cancel} = 0;
    {tx_valid, rx_ready, usb_suspend_det, usb_resume_det, usb_bus_reset} = 0;
    {usb_configured_ev, cfg_mode, cfg_cs_sel, cfg_pre_dly, cfg_gap_dly, cfg_post_dly} = 0;
    {tx_data, cfg_cs_act, cfg_cs_idle, cfg_len} = {8'h00, 9'h000, 9'h1ff, 16'h0003};
    {cfg_half_cyc, pin_func, gen_pin_in} = {17'h0_000a, 18'h0_08a5, 9'h1ff};
    {errors, checks_done} = 0;
    repeat (16) @(negedge clock);
    rst_b = 1;
    for (int r = 0; r < 4; r++) begin
      setup(rows[r], 16'h0003);
      for (int k = 0; k < 3; k++) push(8'h96 ^ 8'(r * 16 + k));
      run(0, 0);
      if (r == 0) base = cyc;
      chk("busy cycles", base + rows[r].pre + 2 * rows[r].gap + rows[r].post, cyc);
      chk("half period", 10, span);
      for (int k = 0; k < 3; k++) pull(k, 8'h96 ^ 8'(r * 16 + k));
    end
    // Fill the transmit side until it refuses, then a full-depth transfer
    setup(rows[0], 16'h0040);
    for (cyc = 0; cyc < 70 && tx_ready === 1'b1; cyc++) push(8'(cyc));
    chk("tx depth", 64, cyc);
    cfg_cs_sel = 9'h001;
    run(1, 0);
    for (int k = 0; k < 64; k++) pull(k, 8'(k));
    chk("rx empty", 0, rx_valid);
    for (int k = 0; k < 3; k++) push(8'h11);
    run(0, 1);
    chk("cancel short", 1, cyc < base);
    // Release request on pin 8 is acknowledged on pin 7 while idle
    pin_func = 18'h2_88a5;
    gen_pin_in = 9'h0ff;
    repeat (4) @(negedge clock);
    chk("release ack", 0, gen_pin_out[7]);
    gen_pin_in = 9'h1ff;
    repeat (4) @(negedge clock);
    chk("release ack", 1, gen_pin_out[7]);
    pulse(usb_configured_ev);
    chk("cfg pin", 0, gen_pin_out[5]);
    pulse(usb_suspend_det);
    chk("suspended", 1, usb_suspended);
    chk("suspend pin", 0, gen_pin_out[2]);
    chk("cfg pin", 1, gen_pin_out[5]);
    pulse(usb_resume_det);
    chk("suspend pin", 1, gen_pin_out[2]);
    chk("cfg pin", 0, gen_pin_out[5]);
    pulse(usb_suspend_det);
    pulse(usb_bus_reset);
    chk("suspended", 0, usb_suspended);
    self_powered_in = 1;
    pulse(self_powered_we);
    chk("power src", 1, self_powered);
    pulse(usb_suspend_det);
    rst_b = 0;
    repeat (2) @(negedge clock);
    rst_b = 1;
    chk("suspended", 0, usb_suspended);
    chk("power src", 0, self_powered);
    chk("cfg pin", 1, gen_pin_out[5]);
    chk("hid only", 1, hid_only);
    for (int k = 0; k < 4; k++) push(8'h5a);
    run(0, 0);
    chk("half period", UHS_DEF_HALF, span);
    for (int k = 0; k < 4; k++) pull(k, 8'h5a);
    close_out();
  end
endmodule
